// [flsp_map.svh]
// Operation
// - Programmer ID: high voltage on address_bit_nine
// - Protect verify: sector address, A1 high, A6/A0 low
// - In-system ID needs identification command sequence
// - Reset-pin method; protect all before unprotect
// - Alternate method: high voltage on three pins
// - Write needs chip select, strobe low, gate high
// - Bad sequence needs reset command afterwards
`ifndef FLSP_MAP_SVH
`define FLSP_MAP_SVH

// Pin and sector geometry
`define FLSP_AW            17
`define FLSP_DW            8
`define FLSP_NSEC          10
`define FLSP_SEC_HI        16
`define FLSP_SEC_LO        12
`define FLSP_BIT_A0        0
`define FLSP_BIT_A1        1
`define FLSP_BIT_A6        6

// Identification low address bytes
`define FLSP_ID_MAKER_LO   8'h00
`define FLSP_ID_DEV_LO     8'h01
`define FLSP_ID_PROT_LO    8'h02

// Timing in ns, and derived clock counts (least times round up)
`define FLSP_CLK_NS        5
`define FLSP_T_GLITCH_NS   5
`define FLSP_T_SETUP_NS    10
`define FLSP_T_STROBE_NS   40
`define FLSP_T_HOLD_NS     10
`define FLSP_T_HV_NS       200
`define FLSP_CYC(t)        (((t) + `FLSP_CLK_NS - 1) / `FLSP_CLK_NS)
`define FLSP_SETUP_CYC     `FLSP_CYC(`FLSP_T_SETUP_NS)
`define FLSP_STROBE_CYC    `FLSP_CYC(`FLSP_T_STROBE_NS)
`define FLSP_HOLD_CYC      `FLSP_CYC(`FLSP_T_HOLD_NS)
`define FLSP_GLITCH_CYC    `FLSP_CYC(`FLSP_T_GLITCH_NS)
`define FLSP_HV_CYC        `FLSP_CYC(`FLSP_T_HV_NS)

`endif

// [flsp_pkg.sv]
`include "flsp_map.svh"

package flsp_pkg;

  // Host command codes
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,  // Plain array read
    OP_WRITE      = 4'h1,  // Raw write cycle
    OP_RESET      = 4'h2,  // Reset command
    OP_ID_ENTER   = 4'h3,  // Identification command sequence
    OP_ID_READ    = 4'h4,  // Maker or device code
    OP_PROT_QUERY = 4'h5,  // In-system protection status
    OP_HV_READ    = 4'h6,  // Programmer path identification read
    OP_PROTECT    = 4'h7,  // Reset-pin method protect
    OP_UNPROTECT  = 4'h8,  // Reset-pin method unprotect
    OP_ALT_PROT   = 4'h9,  // Three-pin high voltage protect
    OP_TEMP_UNPR  = 4'hA   // Temporary unprotect level
  } flsp_op_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_SETUP  = 2'h1,
    BUS_STROBE = 2'h2,
    BUS_HOLD   = 2'h3
  } flsp_bus_st_t;

  typedef enum logic [2:0] {
    HST_IDLE   = 3'h0,
    HST_SETTLE = 3'h1,
    HST_ISSUE  = 3'h2,
    HST_WAIT   = 3'h3,
    HST_DROP   = 3'h4,
    HST_RESP   = 3'h5
  } flsp_hst_t;

  // One bus cycle of a command sequence
  typedef struct packed {
    logic                    wr;
    logic [`FLSP_AW-1:0]     addr;
    logic [`FLSP_DW-1:0]     data;
    logic                    last;
  } flsp_step_t;

  // Bus cycle engine state
  typedef struct packed {
    flsp_bus_st_t            st;
    logic [7:0]              cnt;
    logic                    wr;
    logic [`FLSP_AW-1:0]     a;
    logic [`FLSP_DW-1:0]     d;
    logic [`FLSP_DW-1:0]     rd;
    logic [`FLSP_DW-1:0]     s1;
    logic [`FLSP_DW-1:0]     s2;
    logic                    done;
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
    logic                    dq_oe;
  } flsp_bus_s_t;

  // Sequencer state
  typedef struct packed {
    flsp_hst_t               st;
    flsp_op_t                op;
    logic [1:0]              idx;
    logic [7:0]              cnt;
    logic [`FLSP_AW-1:0]     a;
    logic [`FLSP_DW-1:0]     d;
    logic                    hv_a9;
    logic                    hv_oe;
    logic                    hv_rst;
    logic                    temp;
    logic [`FLSP_NSEC-1:0]   prot;
    logic                    start;
    logic                    rsp_valid;
    logic [`FLSP_DW-1:0]     rsp_data;
    logic                    rsp_err;
  } flsp_host_s_t;

endpackage

// [flsp_bus.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.svh"

// One asynchronous read or write cycle on the flash pins
module flsp_bus (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                start,   // Pulse: begin a cycle
  input  wire logic                wr,      // High for a write cycle
  input  wire logic [`FLSP_AW-1:0] addr,
  input  wire logic [`FLSP_DW-1:0] wdata,
  output logic                     done,    // Pulse: cycle finished
  output logic [`FLSP_DW-1:0]      rdata,   // Captured read data
  output logic                     ce_n,
  output logic                     oe_n,
  output logic                     we_n,
  output logic [`FLSP_AW-1:0]      addr_o,
  output logic [`FLSP_DW-1:0]      dq_o,
  output logic                     dq_oe,
  input  wire logic [`FLSP_DW-1:0] dq_i
);

  flsp_pkg::flsp_bus_s_t q;  // Registered state
  flsp_pkg::flsp_bus_s_t d;  // Next state

  // Next state and next pin levels
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.s1   = dq_i;  // Data pins come from another domain
    d.s2   = q.s1;
    unique case (q.st)
      flsp_pkg::BUS_IDLE: begin
        if (start) begin
          // Address and data settle before any strobe falls
          d.st  = flsp_pkg::BUS_SETUP;
          d.wr  = wr;
          d.a   = addr;
          d.d   = wdata;
          d.cnt = 8'(`FLSP_SETUP_CYC - 1);
        end
      end
      flsp_pkg::BUS_SETUP: begin
        if (q.cnt == 8'h00) begin
          d.st  = flsp_pkg::BUS_STROBE;
          d.cnt = 8'(`FLSP_STROBE_CYC - 1);
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      flsp_pkg::BUS_STROBE: begin
        if (q.cnt == 8'h00) begin
          // Synchroniser adds two cycles; the strobe is far longer
          d.rd  = q.s2;
          d.st  = flsp_pkg::BUS_HOLD;
          d.cnt = 8'(`FLSP_HOLD_CYC - 1);
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      flsp_pkg::BUS_HOLD: begin
        // Data stays driven past the rising strobe
        if (q.cnt == 8'h00) begin
          d.st   = flsp_pkg::BUS_IDLE;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
    endcase
    // Pin levels follow the next state, so they leave flops cleanly
    d.ce_n  = (d.st != flsp_pkg::BUS_STROBE);
    d.we_n  = !(d.st == flsp_pkg::BUS_STROBE && d.wr);
    d.oe_n  = !(d.st == flsp_pkg::BUS_STROBE && !d.wr);
    d.dq_oe = (d.st != flsp_pkg::BUS_IDLE) && d.wr;
  end

  // State register; write strobe held high out of reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q       <= '0;
      q.st    <= flsp_pkg::BUS_IDLE;
      q.ce_n  <= 1'b1;
      q.oe_n  <= 1'b1;
      q.we_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign done   = q.done;
  assign rdata  = q.rd;
  assign ce_n   = q.ce_n;
  assign oe_n   = q.oe_n;
  assign we_n   = q.we_n;
  assign addr_o = q.a;
  assign dq_o   = q.d;
  assign dq_oe  = q.dq_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  write_qualify_a: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
    else $error("write strobe without chip select or with output gate low");
  strobe_width_a: assert property ($fell(we_n) |-> !we_n [*8])
    else $error("write strobe shorter than required");
  addr_stable_a: assert property (!ce_n |-> $stable(addr_o))
    else $error("address moved during strobe");
  data_hold_a: assert property ($rose(we_n) |-> dq_oe && $stable(dq_o))
    else $error("write data dropped at rising strobe");
  cycle_done_a: assert property (start && q.st == flsp_pkg::BUS_IDLE |-> ##[10:20] done)
    else $error("bus cycle did not finish in time");
  write_cycle_c: cover property ($rose(we_n) ##[1:4] done);
  read_cycle_c: cover property ($rose(oe_n) ##[1:4] done);

endmodule
`default_nettype wire

// [flsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.svh"

// Host controller: drives identification, protection and raw cycles
module flsp_host #(
  parameter bit                  TOP_BOOT   = 1'b0,     // Sector layout variant
  parameter logic [`FLSP_AW-1:0] UL1_ADDR   = 17'h00555, // First unlock address
  parameter logic [`FLSP_DW-1:0] UL1_DATA   = 8'hAA,
  parameter logic [`FLSP_AW-1:0] UL2_ADDR   = 17'h002AA, // Second unlock address
  parameter logic [`FLSP_DW-1:0] UL2_DATA   = 8'h55,
  parameter logic [`FLSP_DW-1:0] ID_CMD     = 8'h90,     // Identification command
  parameter logic [`FLSP_DW-1:0] RESET_CMD  = 8'hF0,     // Reset command
  parameter logic [`FLSP_DW-1:0] PROT_DATA  = 8'h60      // Protect/unprotect data
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  // Command port
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic [3:0]          cmd_op,
  input  wire logic [`FLSP_AW-1:0] cmd_addr,
  input  wire logic [`FLSP_DW-1:0] cmd_data,
  output logic                     rsp_valid,
  output logic [`FLSP_DW-1:0]      rsp_data,
  output logic                     rsp_err,
  output logic [`FLSP_NSEC-1:0]    prot_map,     // Known protected sectors
  // Flash pins
  output logic                     ce_n,
  output logic                     oe_n,
  output logic                     we_n,
  output logic [`FLSP_AW-1:0]      addr_o,
  output logic [`FLSP_DW-1:0]      dq_o,
  output logic                     dq_oe,
  input  wire logic [`FLSP_DW-1:0] dq_i,
  output logic                     a9_hv_en,     // high_voltage_level on address_bit_nine
  output logic                     oe_hv_en,     // high_voltage_level on output gate
  output logic                     rst_hv_en     // high_voltage_level on reset pin
);

  flsp_pkg::flsp_host_s_t q;     // Registered state
  flsp_pkg::flsp_host_s_t d;     // Next state
  flsp_pkg::flsp_step_t   step;  // Current sequence step
  logic                   bus_done;
  logic [`FLSP_DW-1:0]    bus_rdata;

  // Sector index from an address, for either boot layout
  function automatic logic [3:0] sector_of(input logic [`FLSP_AW-1:0] a);
    logic [4:0] s;
    s = a[`FLSP_SEC_HI:`FLSP_SEC_LO];
    if (!TOP_BOOT) begin
      if (s[4:2] != 3'h0) sector_of = 4'(s[4:2]) + 4'h2;
      else if (!s[1])     sector_of = 4'h0;
      else                sector_of = s[0] ? 4'h2 : 4'h1;
    end else begin
      if (s[4:2] != 3'h7) sector_of = 4'(s[4:2]);
      else if (s[1])      sector_of = 4'h9;  // 8K sector at the very top
      else                sector_of = s[0] ? 4'h8 : 4'h7;
    end
  endfunction

  // Force the three mode address bits
  function automatic logic [`FLSP_AW-1:0] mode_addr(input logic [`FLSP_AW-1:0] a,
                                                  input logic a6, input logic a1,
                                                  input logic a0);
    mode_addr              = a;
    mode_addr[`FLSP_BIT_A6] = a6;
    mode_addr[`FLSP_BIT_A1] = a1;
    mode_addr[`FLSP_BIT_A0] = a0;
  endfunction

  // Address, data and direction of each step of each command
  always_comb begin
    step      = '0;
    step.last = 1'b1;
    step.addr = q.a;
    step.data = q.d;
    unique case (q.op)
      flsp_pkg::OP_READ: ;
      flsp_pkg::OP_WRITE:     step.wr = 1'b1;
      flsp_pkg::OP_RESET: begin
        // Any address is accepted with the reset command
        step.wr   = 1'b1;
        step.data = RESET_CMD;
      end
      flsp_pkg::OP_ID_ENTER: begin
        // Two unlock cycles, then the identification command
        step.wr   = 1'b1;
        step.last = (q.idx == 2'h2);
        step.addr = (q.idx == 2'h1) ? UL2_ADDR : UL1_ADDR;
        step.data = (q.idx == 2'h0) ? UL1_DATA : (q.idx == 2'h1) ? UL2_DATA : ID_CMD;
      end
      flsp_pkg::OP_ID_READ: begin
        step.addr = {q.a[`FLSP_AW-1:8], q.d[0] ? `FLSP_ID_DEV_LO : `FLSP_ID_MAKER_LO};
      end
      flsp_pkg::OP_PROT_QUERY: begin
        step.addr = {q.a[`FLSP_AW-1:8], `FLSP_ID_PROT_LO};
      end
      flsp_pkg::OP_HV_READ: begin
        // Bit 1 of the command data picks sector verify over code read
        step.addr = mode_addr(q.a, 1'b0, q.d[1], q.d[0] & ~q.d[1]);
      end
      flsp_pkg::OP_PROTECT, flsp_pkg::OP_ALT_PROT: begin
        step.wr   = 1'b1;
        step.addr = mode_addr(q.a, 1'b0, 1'b1, 1'b0);
        step.data = PROT_DATA;
      end
      flsp_pkg::OP_UNPROTECT: begin
        step.wr   = 1'b1;
        step.addr = mode_addr(q.a, 1'b1, 1'b1, 1'b0);
        step.data = PROT_DATA;
      end
      default: ;  // Temporary unprotect runs no cycle; unused codes run a plain read cycle
    endcase
  end

  // Sequencer next state
  always_comb begin
    d           = q;
    d.start     = 1'b0;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      flsp_pkg::HST_IDLE: begin
        if (cmd_valid) begin
          d.op      = flsp_pkg::flsp_op_t'(cmd_op);
          d.a       = cmd_addr;
          d.d       = cmd_data;
          d.idx     = 2'h0;
          d.rsp_err = 1'b0;
          if (d.op == flsp_pkg::OP_TEMP_UNPR) d.temp = cmd_data[0];
          if (d.op == flsp_pkg::OP_UNPROTECT && !(&q.prot)) begin
            // Every sector must be protected before an unprotect write
            d.rsp_err = 1'b1;
            d.op      = flsp_pkg::OP_READ;  // No level rises for a refused command
            d.st      = flsp_pkg::HST_RESP;
          end else begin
            d.st  = flsp_pkg::HST_SETTLE;
            d.cnt = 8'(`FLSP_HV_CYC - 1);
          end
        end
      end
      flsp_pkg::HST_SETTLE: begin
        // High voltage pins need time before a strobe is allowed
        if (q.cnt != 8'h00)                   d.cnt = q.cnt - 8'h01;
        else if (q.op == flsp_pkg::OP_TEMP_UNPR) d.st = flsp_pkg::HST_RESP;
        else                                  d.st  = flsp_pkg::HST_ISSUE;
      end
      flsp_pkg::HST_ISSUE: begin
        d.start = 1'b1;
        d.st    = flsp_pkg::HST_WAIT;
      end
      flsp_pkg::HST_WAIT: begin
        if (bus_done) begin
          d.rsp_data = bus_rdata;
          if (!step.last) begin
            d.idx = q.idx + 2'h1;
            d.st  = flsp_pkg::HST_ISSUE;
          end else begin
            d.st  = flsp_pkg::HST_DROP;
            d.cnt = 8'(`FLSP_HV_CYC - 1);
            unique case (q.op)
              flsp_pkg::OP_PROT_QUERY: d.prot[sector_of(q.a)] = (bus_rdata != 8'h00);
              flsp_pkg::OP_HV_READ:
                if (q.d[1]) d.prot[sector_of(q.a)] = (bus_rdata != 8'h00);
              flsp_pkg::OP_PROTECT, flsp_pkg::OP_ALT_PROT: d.prot[sector_of(q.a)] = 1'b1;
              flsp_pkg::OP_UNPROTECT: d.prot = '0;
              default: ;
            endcase
          end
        end
      end
      flsp_pkg::HST_DROP: begin
        // The levels are removed and given time to settle before the answer
        d.op = flsp_pkg::OP_READ;
        if (q.cnt != 8'h00) d.cnt = q.cnt - 8'h01;
        else                d.st  = flsp_pkg::HST_RESP;
      end
      flsp_pkg::HST_RESP: begin
        d.rsp_valid = 1'b1;
        d.op        = flsp_pkg::OP_READ;
        d.st        = flsp_pkg::HST_IDLE;
      end
      default: d.st = flsp_pkg::HST_IDLE;  // Two codes unused
    endcase
    // Levels follow the command in hand; kept here so no loop runs through d
    d.hv_a9  = (d.op == flsp_pkg::OP_HV_READ) || (d.op == flsp_pkg::OP_ALT_PROT);
    d.hv_oe  = (d.op == flsp_pkg::OP_ALT_PROT);
    d.hv_rst = d.temp || (d.op == flsp_pkg::OP_PROTECT) || d.hv_oe
               || (d.op == flsp_pkg::OP_UNPROTECT);
  end

  // State register; sector flags start clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q      <= '0;
      q.st   <= flsp_pkg::HST_IDLE;
      q.op   <= flsp_pkg::OP_READ;
    end else begin
      q <= d;
    end
  end

  flsp_bus u_bus (
    .clk    (clk),
    .rstn   (rstn),
    .start  (q.start),
    .wr     (step.wr),
    .addr   (step.addr),
    .wdata  (step.data),
    .done   (bus_done),
    .rdata  (bus_rdata),
    .ce_n   (ce_n),
    .oe_n   (oe_n),
    .we_n   (we_n),
    .addr_o (addr_o),
    .dq_o   (dq_o),
    .dq_oe  (dq_oe),
    .dq_i   (dq_i)
  );

  assign cmd_ready = (q.st == flsp_pkg::HST_IDLE);
  assign rsp_valid = q.rsp_valid;
  assign rsp_data  = q.rsp_data;
  assign rsp_err   = q.rsp_err;
  assign prot_map  = q.prot;
  assign a9_hv_en  = q.hv_a9;
  assign oe_hv_en  = q.hv_oe;
  assign rst_hv_en = q.hv_rst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  unprot_refuse_a: assert property (cmd_valid && cmd_ready && cmd_op == 4'h8 && !(&q.prot)
                                    |-> ##1 $stable(rst_hv_en) ##1 rsp_valid && rsp_err
                                        && we_n && $stable(rst_hv_en))
    else $error("unprotect not refused while a sector is unprotected");
  alt_levels_a: assert property (oe_hv_en |-> a9_hv_en && rst_hv_en)
    else $error("alternate method without all three high voltage pins");
  hv_settle_a: assert property ($rose(a9_hv_en) |-> ce_n [*8])
    else $error("strobe too soon after high voltage applied");
  id_enter_a: assert property (q.op == flsp_pkg::OP_ID_ENTER && q.idx == 2'h2 && !we_n
                               |-> dq_o == ID_CMD && addr_o == UL1_ADDR)
    else $error("identification command missing");
  reset_cmd_a: assert property (q.op == flsp_pkg::OP_RESET && !we_n |-> dq_o == RESET_CMD)
    else $error("reset command data wrong");
  id_enter_c: cover property (q.op == flsp_pkg::OP_ID_ENTER && bus_done && step.last);
  protect_c: cover property (q.op == flsp_pkg::OP_PROTECT && bus_done);
  refuse_c: cover property (rsp_valid && rsp_err);

endmodule
`default_nettype wire

// [flsp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.svh"

// Behavioural bottom-boot flash: command decode, ID codes, sector flags
module flsp_dev_model #(
  parameter logic [7:0] MAKER = 8'hA5,  // Arbitrary maker code
  parameter logic [7:0] DEVID = 8'h3C   // Arbitrary device code
) (
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        a9_hv,
  input  wire logic        oe_hv,
  input  wire logic        rst_hv,
  output logic      [7:0]  dq_out
);
  logic [9:0]  prot = 10'h000; // All clear on delivery
  logic [1:0]  seq  = 2'h0;    // Unlock progress
  logic        idm  = 1'b0;    // Identification mode
  logic [16:0] al;             // Latched address
  logic [7:0]  last = 8'h00;   // Last byte driven
  realtime     t_fall = 1.0e9; // Start of the last write cycle; far future at power-up and after a glitch
  // High voltage on the gate pin reads as a logic one
  wire wcyc = !ce_n && !we_n && (oe_n || oe_hv);
  wire rd   = !ce_n && !oe_n && we_n;

  // Sector index from address bits 16..12
  function automatic int sec(input logic [16:0] a);
    if (a[16:14] != 3'h0) return a[16:14] + 2;
    if (!a[13]) return 0;
    return a[12] ? 2 : 1;
  endfunction

  // Address taken when the later strobe falls
  always @(posedge wcyc) begin
    al     = addr;
    t_fall = $realtime;
  end
  // Data taken when the earlier strobe rises; a glitch, or a cycle already
  // open at power-up with no recorded start, is thrown away
  always @(negedge wcyc) begin
    if ($realtime - t_fall < 5.0) t_fall = 1.0e9;
    else if (rst_hv && a9_hv && oe_hv) prot[sec(al)] = 1'b1;
    else if (rst_hv && al[1] && !al[0]) begin
      // Unprotect is ignored unless every sector is protected first
      if (!al[6]) prot[sec(al)] = 1'b1;
      else if (&prot) prot = 10'h000;
    end else if (dq == 8'hF0) begin
      seq = 2'h0;
      idm = 1'b0;
    end else if (seq == 2'h0 && al[11:0] == 12'h555 && dq == 8'hAA) seq = 2'h1;
    else if (seq == 2'h1 && al[11:0] == 12'h2AA && dq == 8'h55) seq = 2'h2;
    else if (seq == 2'h2 && dq == 8'h90) begin
      seq = 2'h0;
      idm = 1'b1;
    end else seq = 2'h0;
  end

  // Read data; a released bus shows the inverse, never a stale byte
  always @* begin
    dq_out = ~last;
    if (rd && (a9_hv || idm)) begin
      case (addr[1:0])
        2'h0: dq_out = MAKER;
        2'h1: dq_out = DEVID;
        default: dq_out = {7'h00, prot[sec(addr)]};
      endcase
    end else if (rd) dq_out = addr[7:0] ^ 8'h5A;
  end
  always @(dq_out) if (rd) last = dq_out;
endmodule
`default_nettype wire

// [flsp_host_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.svh"

// Self-checking bench for the flash host controller
module flsp_host_bench;
  logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_err;
  logic [3:0]  cmd_op = 4'h0;
  logic [16:0] cmd_addr = 17'h00000, addr_o, wa;
  logic [7:0]  cmd_data = 8'h00, rsp_data, dq_o, dq_i, wd;
  logic [9:0]  prot_map;
  logic        ce_n, oe_n, we_n, dq_oe, a9_hv_en, oe_hv_en, rst_hv_en;
  logic [2:0]  seen;       // High-voltage enables seen during a command
  int          num_errors = 0, n_tests = 0, wfalls = 0;

  flsp_host dut_u (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .prot_map(prot_map), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr_o(addr_o), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i), .a9_hv_en(a9_hv_en), .oe_hv_en(oe_hv_en), .rst_hv_en(rst_hv_en));
  flsp_dev_model dev_u (.addr(addr_o), .dq(dq_o), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .a9_hv(a9_hv_en), .oe_hv(oe_hv_en), .rst_hv(rst_hv_en), .dq_out(dq_i));

  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  // Cleared at the edge that takes a command, so one process owns it
  always @(posedge clk)
    seen <= (cmd_valid && cmd_ready) ? 3'h0 : (seen | {a9_hv_en, oe_hv_en, rst_hv_en});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Offer one command when idle, then wait a bounded time for the answer
  task automatic run(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && i < 2000) begin @(negedge clk); i++; end
    cmd_op = op; cmd_addr = a; cmd_data = d; cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 4000) begin @(negedge clk); i++; end
    chk(i < 4000, 1'b1);
  endtask

  // Qualifier pins checked after the fall; address and data at the rise must match those taken after the fall
  always @(negedge we_n) begin
    #1;
    wfalls++; wa = addr_o; wd = dq_o;
    chk({ce_n, oe_n | oe_hv_en, dq_oe}, 3'b011);
  end
  always @(posedge we_n) if (rstn) chk({addr_o, dq_o}, {wa, wd});

  task automatic t_reset;
    chk({ce_n, oe_n, we_n, dq_oe, a9_hv_en, oe_hv_en, rst_hv_en, cmd_ready}, 8'hE1);
    chk(prot_map, 10'h000);
  endtask
  task automatic t_hv_id;
    run(4'h6, 17'h00000, 8'h00); chk(rsp_data, 8'hA5);
    chk(seen, 3'h4);
    run(4'h6, 17'h00001, 8'h01); chk(rsp_data, 8'h3C);
  endtask
  task automatic t_cmd_id;
    run(4'h3, 17'h00000, 8'h00); chk(seen, 3'h0);
    run(4'h4, 17'h00000, 8'h00); chk(rsp_data, 8'hA5);
    run(4'h4, 17'h00001, 8'h01); chk(rsp_data, 8'h3C);
    run(4'h5, 17'h03002, 8'h00); chk(rsp_data, 8'h00);
    run(4'h2, 17'h1ABCD, 8'h00);
    run(4'h0, 17'h00012, 8'h00); chk(rsp_data, 8'h48);
  endtask
  task automatic t_refuse;
    wfalls = 0;
    run(4'h8, 17'h00042, 8'h00); chk(rsp_err, 1'b1);
    chk(wfalls, 0);
    chk(seen, 3'h0);
  endtask
  task automatic t_protect;
    run(4'h7, 17'h02002, 8'h00); chk(prot_map, 10'h002);
    chk(seen, 3'h1);
    run(4'h6, 17'h02002, 8'h02); chk(rsp_data, 8'h01);
    run(4'h6, 17'h04002, 8'h02); chk(rsp_data, 8'h00);
  endtask
  task automatic t_alt;
    run(4'h9, 17'h14002, 8'h00); chk(seen, 3'h7);
    run(4'h6, 17'h14002, 8'h02); chk(rsp_data, 8'h01);
  endtask
  task automatic t_unprot;
    for (int i = 0; i < 10; i++)
      run(4'h7, 17'((i < 3) ? 32'h00002 + (i << 12) + (i > 0 ? 32'h01000 : 32'h0)
                            : 32'h00002 + ((i - 2) << 14)), 8'h00);
    chk(prot_map, 10'h3FF);
    run(4'h8, 17'h00042, 8'h00); chk({rsp_err, prot_map}, 11'h000);
    run(4'h6, 17'h02002, 8'h02); chk(rsp_data, 8'h00);
  endtask
  task automatic t_temp;
    run(4'hA, 17'h00000, 8'h01); chk(rst_hv_en, 1'b1);
    run(4'hA, 17'h00000, 8'h00); chk(rst_hv_en, 1'b0);
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence: 8-cycle reset, then every scenario in turn
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset;
    t_hv_id;
    t_cmd_id;
    t_refuse;
    t_protect;
    t_alt;
    t_unprot;
    t_temp;
    complete_run;
  end
  // Watchdog: 28 commands of about a hundred cycles each fit easily
  initial begin
    #300000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire
